// >>> hw/rtcft_params.svh
// Constants for the fixed-cycle timer block of the real time clock.
// Assumes a 25 MHz APB clock; included by the timer module only.
// What this block does
// [R01] Setting the run bit starts the countdown from the preset, never a partial count.
// [R02] Decrement once per selected tick; event when count goes from one to zero.
// [R03] After each event reload the preset and keep counting, repeating.
// [R04] Each event sets the timer flag; it stays set until software writes zero.
// [R05] Event pulls the interrupt pin low only when timer interrupt enable is set.
// [R06] Pin stays low at most the auto-release time, then floats; next event pulls again.
// [R07] Writing zero to the run bit stops counting and releases the pin.
// [R08] Clearing the timer flag releases a low pin at once.
// [R09] Clearing the timer interrupt enable releases a low pin at once.
// [R10] Source select: 00 4096 Hz, 01 64 Hz, 10 second update, 11 minute update.
// [R11] Auto-release 122 us with 4096 Hz source, 7.8125 ms with the others.
// [R12] Under clock halt or sub-second reset, only the 4096 Hz source keeps running.
// [R13] Second and minute sources step exactly on the calendar update instants.
// [R14] Twelve-bit preset: low register bits 7:0, high register bits 3:0; upper nibble is RAM.
// [R15] Fixed-zero bits ignore writes and read as zero.
// [R16] Software may use the preset registers as RAM after stopping the timer.
// [R17] Software should clear run and interrupt enable before changing settings.
// [R18] Sub-second reset bit clears the sub-second divider; chip enable low ends it.
// [R19] Interrupt pin is shared with update, alarm and event requests, ORed.
// [R20] Each register answers at its lower and upper bank offset, same storage.
`ifndef RTCFT_PARAMS_SVH
`define RTCFT_PARAMS_SVH

// Register indexes; byte address is four times the index
`define RTCFT_IDX_PRESET_LO 6'h0b
`define RTCFT_IDX_PRESET_HI 6'h0c
`define RTCFT_IDX_EXT_CTRL  6'h0d
`define RTCFT_IDX_FLAGS     6'h0e
`define RTCFT_IDX_IRQ_CTRL  6'h0f
`define RTCFT_IDX_BANK_BIT  4

// Extension control fields
`define RTCFT_EXT_RUN_BIT   4
`define RTCFT_EXT_TSEL_HI   1
`define RTCFT_EXT_TSEL_LO   0
// Flag fields; bits 7:6 fixed zero
`define RTCFT_FLG_TF_BIT    4
`define RTCFT_FLG_ZERO_MASK 8'hc0
// Interrupt control fields; bit 1 fixed zero
`define RTCFT_CTL_TIE_BIT   4
`define RTCFT_CTL_RST_BIT   0
`define RTCFT_CTL_ZERO_MASK 8'h02

`define RTCFT_RESET_BYTE    8'h00

// Timing
`define RTCFT_PCLK_NS       40
`define RTCFT_RTN_FAST_NS   122000
`define RTCFT_RTN_SLOW_NS   7812500
`define RTCFT_RTN_FAST_CYC  (`RTCFT_RTN_FAST_NS / `RTCFT_PCLK_NS)
`define RTCFT_RTN_SLOW_CYC  (`RTCFT_RTN_SLOW_NS / `RTCFT_PCLK_NS)

`endif

// >>> hw/rtcft_pkg.sv
// Types for the fixed-cycle timer block.
// Assumes rtcft_params.svh is on the include path.
package rtcft_pkg;

    // Tick enables from the calendar divider chain, one-cycle pulses on pclk
    typedef struct packed {
        logic tick_4096;
        logic tick_64;
        logic sec_update;
        logic min_update;
    } rtcft_ticks_t;

    // Shared interrupt requests of the other calendar functions
    typedef struct packed {
        logic update_req;
        logic alarm_req;
        logic event_req;
    } rtcft_irq_reqs_t;

    typedef enum logic [5:0] {
        RTCFT_SEL_NONE = 6'b000001,
        RTCFT_SEL_PLO  = 6'b000010,
        RTCFT_SEL_PHI  = 6'b000100,
        RTCFT_SEL_EXT  = 6'b001000,
        RTCFT_SEL_FLG  = 6'b010000,
        RTCFT_SEL_CTL  = 6'b100000
    } rtcft_sel_t;

    typedef enum logic [1:0] {
        RTCFT_PIN_FLOAT = 2'b01,
        RTCFT_PIN_LOW   = 2'b10
    } rtcft_pin_t;

endpackage

// >>> hw/rtcft_timer.sv
// Fixed-cycle timer of the real time clock: preset, countdown, flag, pin release.
// Assumes tick pulses and other interrupt requests come from logic on pclk;
// the chip enable pin is asynchronous and is synchronised here.
`timescale 1ns/1ns
`default_nettype none
`include "rtcft_params.svh"

module rtcft_timer
    import rtcft_pkg::*;
#(
    parameter int unsigned RTN_SLOW_CYC = `RTCFT_RTN_SLOW_CYC
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire rtcft_ticks_t    ticks,
    input  wire rtcft_irq_reqs_t other_reqs,
    input  wire logic [4:0]      other_flags,
    input  wire logic            clock_halt,
    input  wire logic            chip_enable,
    output logic                 subsec_reset,
    output logic                 irq_n_out,
    output logic                 irq_n_oe
);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------

    localparam logic [17:0] RTN_FAST = 18'(`RTCFT_RTN_FAST_CYC);
    localparam logic [17:0] RTN_SLOW = 18'(RTN_SLOW_CYC);

    logic [7:0]  preset_lo;
    logic [7:0]  preset_hi;
    logic [7:0]  ext_ctrl;
    logic [7:0]  irq_ctrl;
    logic        timer_event_flag;
    logic [11:0] count;
    logic        run_d;
    logic [17:0] rtn_cnt;
    logic        ce_meta;
    logic        ce_sync;
    rtcft_pin_t  pin_state;
    rtcft_sel_t  sel;
    logic        wr_en;
    logic [7:0]  wbyte;
    logic [7:0]  flags_view;

    // Both banks map to the same storage; bit 4 of the index is ignored
    function automatic rtcft_sel_t decode(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        idx[`RTCFT_IDX_BANK_BIT] = 1'b0; // R20
        decode = RTCFT_SEL_NONE;
        if (addr[1:0] == 2'h0 && addr[7] == 1'b0) begin
            case (idx)
                `RTCFT_IDX_PRESET_LO: decode = RTCFT_SEL_PLO;
                `RTCFT_IDX_PRESET_HI: decode = RTCFT_SEL_PHI;
                `RTCFT_IDX_EXT_CTRL:  decode = RTCFT_SEL_EXT;
                `RTCFT_IDX_FLAGS:     decode = RTCFT_SEL_FLG;
                `RTCFT_IDX_IRQ_CTRL:  decode = RTCFT_SEL_CTL;
                default:              decode = RTCFT_SEL_NONE;
            endcase
        end
    endfunction

    // Zero-wait slave: data is latched in setup, so access always ends at once
    assign sel     = decode(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (sel == RTCFT_SEL_NONE);
    assign wr_en   = psel & penable & pwrite & pstrb[0];
    assign wbyte   = pwdata[7:0];

    wire timer_run   = ext_ctrl[`RTCFT_EXT_RUN_BIT];
    wire [1:0] tsel  = ext_ctrl[`RTCFT_EXT_TSEL_HI:`RTCFT_EXT_TSEL_LO];
    wire timer_irq_enable = irq_ctrl[`RTCFT_CTL_TIE_BIT];
    wire [11:0] preset = {preset_hi[3:0], preset_lo}; // R14

    wire wr_plo = wr_en & (sel == RTCFT_SEL_PLO);
    wire wr_phi = wr_en & (sel == RTCFT_SEL_PHI);
    wire wr_ext = wr_en & (sel == RTCFT_SEL_EXT);
    wire wr_flg = wr_en & (sel == RTCFT_SEL_FLG);
    wire wr_ctl = wr_en & (sel == RTCFT_SEL_CTL);

    // Only the timer flag is held here; the rest belong to the calendar
    assign flags_view = {2'h0, other_flags[4], timer_event_flag, other_flags[3:0]}; // R15

    // Read data latched in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (sel)
                RTCFT_SEL_PLO: prdata <= {24'h000000, preset_lo};
                RTCFT_SEL_PHI: prdata <= {24'h000000, preset_hi}; // R14
                RTCFT_SEL_EXT: prdata <= {24'h000000, ext_ctrl};
                RTCFT_SEL_FLG: prdata <= {24'h000000, flags_view};
                RTCFT_SEL_CTL: prdata <= {24'h000000, irq_ctrl};
                default:       prdata <= 32'h00000000;
            endcase
        end
    end

    // Preset registers, plain storage when the timer is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preset_lo <= `RTCFT_RESET_BYTE;
            preset_hi <= `RTCFT_RESET_BYTE;
        end else begin
            if (wr_plo) begin
                preset_lo <= wbyte;
            end
            if (wr_phi) begin
                preset_hi <= wbyte; // R14
            end
        end
    end

    // Extension control holds run bit and source select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_ctrl <= `RTCFT_RESET_BYTE;
        end else if (wr_ext) begin
            ext_ctrl <= wbyte;
        end
    end

    // ----------------------------------------------------------------
    // Sub-second reset and chip enable
    // ----------------------------------------------------------------

    // Chip enable pin comes from outside; two stages before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_meta <= 1'b0;
            ce_sync <= 1'b0;
        end else begin
            ce_meta <= chip_enable;
            ce_sync <= ce_meta;
        end
    end

    // Interrupt control; reset bit self-clears once chip enable goes low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ctrl <= `RTCFT_RESET_BYTE;
        end else if (wr_ctl) begin
            irq_ctrl <= wbyte & ~`RTCFT_CTL_ZERO_MASK; // R15
        end else if (!ce_sync) begin
            irq_ctrl[`RTCFT_CTL_RST_BIT] <= 1'b0; // R18
        end
    end

    assign subsec_reset = irq_ctrl[`RTCFT_CTL_RST_BIT]; // R18

    // ----------------------------------------------------------------
    // Countdown
    // ----------------------------------------------------------------

    logic sel_tick;
    // Second and minute pulses are the calendar's own update strobes
    always_comb begin
        case (tsel)
            2'h0:    sel_tick = ticks.tick_4096; // R10
            2'h1:    sel_tick = ticks.tick_64;
            2'h2:    sel_tick = ticks.sec_update; // R13
            2'h3:    sel_tick = ticks.min_update; // R13
            default: sel_tick = 1'b0;
        endcase
    end

    // Halted timekeeping freezes every source except the raw 4096 Hz one
    wire halted     = clock_halt | subsec_reset;
    wire may_count  = !halted || tsel == 2'h0; // R12
    wire start      = timer_run & ~run_d;
    wire step       = timer_run & ~start & may_count & sel_tick;
    wire timer_evt  = step & (count == 12'h001); // R02

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_d <= 1'b0;
        end else begin
            run_d <= timer_run;
        end
    end

    // Preset 0 never fires: it just reloads itself each tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 12'h000;
        end else if (start) begin
            count <= preset; // R01
        end else if (step) begin
            if (count <= 12'h001) begin
                count <= preset; // R03
            end else begin
                count <= count - 12'h001; // R02
            end
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_event_flag <= 1'b0;
        end else if (timer_evt) begin
            timer_event_flag <= 1'b1; // R04
        end else if (wr_flg && !wbyte[`RTCFT_FLG_TF_BIT]) begin
            timer_event_flag <= 1'b0; // R04
        end
    end

    // ----------------------------------------------------------------
    // Interrupt pin
    // ----------------------------------------------------------------

    wire tf_fall  = timer_event_flag & wr_flg & ~wbyte[`RTCFT_FLG_TF_BIT] & ~timer_evt;
    wire tie_fall = timer_irq_enable & wr_ctl & ~wbyte[`RTCFT_CTL_TIE_BIT];
    wire te_off   = wr_ext & ~wbyte[`RTCFT_EXT_RUN_BIT];
    wire cancel   = tf_fall | tie_fall | te_off;
    wire pull     = timer_evt & timer_irq_enable & ~cancel; // R05

    // Low for the release time of the active source, or until cancelled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_state <= RTCFT_PIN_FLOAT;
            rtn_cnt   <= 18'h00000;
        end else begin
            case (pin_state)
                RTCFT_PIN_FLOAT: begin
                    if (pull) begin
                        pin_state <= RTCFT_PIN_LOW;
                        rtn_cnt   <= (tsel == 2'h0) ? RTN_FAST : RTN_SLOW; // R11
                    end
                end
                RTCFT_PIN_LOW: begin
                    if (cancel) begin
                        pin_state <= RTCFT_PIN_FLOAT; // R07 R08 R09
                    end else if (pull) begin
                        rtn_cnt <= (tsel == 2'h0) ? RTN_FAST : RTN_SLOW; // R06
                    end else if (rtn_cnt <= 18'h00001) begin
                        pin_state <= RTCFT_PIN_FLOAT; // R06
                    end else begin
                        rtn_cnt <= rtn_cnt - 18'h00001;
                    end
                end
                default: pin_state <= RTCFT_PIN_FLOAT;
            endcase
        end
    end

    wire timer_pull = (pin_state == RTCFT_PIN_LOW);

    // Open drain: drive low only, any enabled source pulls
    assign irq_n_out = 1'b0;
    assign irq_n_oe  = timer_pull | other_reqs.update_req | other_reqs.alarm_req
                     | other_reqs.event_req; // R19

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [17:0] low_cycles;
    // Counts how long the timer has held the pin low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cycles <= 18'h00000;
        end else if (pull || !timer_pull) begin
            low_cycles <= 18'h00000;
        end else begin
            low_cycles <= low_cycles + 18'h00001;
        end
    end

    sequence s_underflow;
        step && count == 12'h001;
    endsequence

    sequence s_reloaded;
        count == $past(preset) && timer_event_flag;
    endsequence

    property p_start_preset;
        start |=> count == $past(preset);
    endproperty
    a_start_preset: assert property (p_start_preset) else $error("start not from preset"); // R01

    property p_decrement;
        step && count > 12'h001 |=> count == $past(count) - 12'h001;
    endproperty
    a_decrement: assert property (p_decrement) else $error("count did not step down"); // R02

    property p_underflow_reload;
        s_underflow |=> s_reloaded;
    endproperty
    a_underflow_reload: assert property (p_underflow_reload) else $error("no reload or flag"); // R03

    property p_flag_sticky;
        timer_event_flag && !wr_flg |=> timer_event_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("timer flag lost"); // R04

    property p_pull_needs_tie;
        $rose(timer_pull) |-> $past(timer_irq_enable) && $past(timer_evt);
    endproperty
    a_pull_needs_tie: assert property (p_pull_needs_tie) else $error("pin pulled wrongly"); // R05

    property p_release_bound;
        timer_pull |-> low_cycles < ((tsel == 2'h0) ? RTN_FAST : RTN_SLOW);
    endproperty
    a_release_bound: assert property (p_release_bound) else $error("pin low too long"); // R06

    property p_cancel_release;
        cancel |=> !timer_pull;
    endproperty
    a_cancel_release: assert property (p_cancel_release) else $error("pin not released"); // R07

    property p_halt_freeze;
        halted && tsel != 2'h0 && !start |=> $stable(count);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("count moved while halted"); // R12

    property p_zero_bits;
        (prdata[31:8] == 24'h000000) && ((irq_ctrl & `RTCFT_CTL_ZERO_MASK) == 8'h00);
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("fixed zero bit set"); // R15

    property p_ce_ends_reset;
        !ce_sync && !wr_ctl |=> !subsec_reset;
    endproperty
    a_ce_ends_reset: assert property (p_ce_ends_reset) else $error("reset bit kept"); // R18

    property p_tf_release;
        timer_event_flag && !timer_evt && wr_flg && !wbyte[`RTCFT_FLG_TF_BIT] |=> !timer_pull;
    endproperty
    a_tf_release: assert property (p_tf_release) else $error("pin kept"); // R08

    property p_tie_release;
        timer_irq_enable && wr_ctl && !wbyte[`RTCFT_CTL_TIE_BIT] |=> !timer_pull;
    endproperty
    a_tie_release: assert property (p_tie_release) else $error("pin kept on tie"); // R09

    property p_no_tick_hold;
        timer_run && !start && !sel_tick |=> $stable(count);
    endproperty
    a_no_tick_hold: assert property (p_no_tick_hold) else $error("count moved"); // R10

    property p_rtn_load;
        pull |=> rtn_cnt == (($past(tsel) == 2'h0) ? RTN_FAST : RTN_SLOW);
    endproperty
    a_rtn_load: assert property (p_rtn_load) else $error("wrong release time"); // R11

    property p_preset_high;
        wr_phi |=> preset_hi == $past(wbyte) && preset[11:8] == $past(wbyte[3:0]);
    endproperty
    a_preset_high: assert property (p_preset_high) else $error("preset high wrong"); // R14

    property p_shared_pin;
        other_reqs != 3'h0 |-> irq_n_oe && !irq_n_out;
    endproperty
    a_shared_pin: assert property (p_shared_pin) else $error("shared pin idle"); // R19

endmodule
`default_nettype wire

// >>> sim/rtcft_cal_model.sv
// Calendar-side model: turns bench requests into one-cycle tick strobes.
// Assumes requests change just after a rising pclk edge.
`timescale 1ns/1ns
`default_nettype none

module rtcft_cal_model
    import rtcft_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [3:0]   fire,
    output var  rtcft_ticks_t ticks
);
    // ------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------
    // One cycle per request, so each request is exactly one tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks <= '0;
        end else begin
            ticks <= rtcft_ticks_t'(fire);
        end
    end
endmodule

`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the fixed-cycle timer over APB.
// Assumes the calendar model supplies the tick strobes.
`timescale 1ns/1ns
`default_nettype none

module tb;
    import rtcft_pkg::*;
    localparam int SLOW = 50;
    localparam int FAST = 3050;
    logic            pclk = 0;
    logic            presetn = 0;
    logic            psel = 0;
    logic            penable = 0;
    logic            pwrite = 0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0;
    logic [3:0]      pstrb = 4'h0;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [3:0]      fire = 4'h0;
    rtcft_ticks_t    ticks;
    rtcft_irq_reqs_t other_reqs = '0;
    logic [4:0]      other_flags = 5'b10101;
    logic            clock_halt = 0;
    logic            chip_enable = 1;
    logic            subsec_reset;
    logic            irq_n_out;
    logic            irq_n_oe;
    logic [31:0]     rdat;
    logic            rerr;
    int              fails = 0;
    int              compares = 0;

    always #20 pclk = ~pclk;

    rtcft_cal_model cal (.pclk(pclk), .presetn(presetn), .fire(fire), .ticks(ticks));

    rtcft_timer #(.RTN_SLOW_CYC(SLOW)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ticks(ticks),
        .other_reqs(other_reqs), .other_flags(other_flags),
        .clock_halt(clock_halt), .chip_enable(chip_enable),
        .subsec_reset(subsec_reset), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Verdict printed in one place only
    task automatic summarize;
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; entered just after an edge, leaves one idle cycle
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        pstrb <= 4'h1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            summarize();
        end
        @(posedge pclk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00);
        chk(rdat, {24'h0, e});
    endtask

    // Pulses of source s; spaced so each is counted before the next
    task automatic tk(input int s, input int n);
        repeat (n) begin
            fire <= 4'b1000 >> s;
            @(posedge pclk);
            fire <= 4'h0;
            repeat (3) @(posedge pclk);
        end
    endtask

    // Pin must float no later than the release time after the event
    task automatic rel(input int rtn);
        int n;
        n = 0;
        while (irq_n_oe === 1'b1 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n >= rtn - 6 && n <= rtn), 32'h1);
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 11; i < 16; i++) begin
            rd(6'(i), (i == 14) ? 8'h25 : 8'h00);
        end
        wr(6'h0b, 8'ha5);
        rd(6'h1b, 8'ha5);
        chk(32'(rerr), 32'h0);
        wr(6'h1c, 8'hf3);
        rd(6'h0c, 8'hf3);
        wr(6'h0e, 8'hff);
        rd(6'h1e, 8'h25);
        wr(6'h0f, 8'hff);
        rd(6'h0f, 8'hfd);
        chk(32'(subsec_reset), 32'h1);
        chk(32'(irq_n_out), 32'h0);
        chip_enable <= 1'b0;
        repeat (5) @(posedge pclk);
        rd(6'h0f, 8'hfc);
        chip_enable <= 1'b1;
        wr(6'h0f, 8'h00);
        xfer(1'b0, 6'h10, 8'h00);
        chk(32'(rerr), 32'h1);
        chk(rdat, 32'h0);
        // Stopped before reprogramming, so no stray request
        wr(6'h0b, 8'h03);
        wr(6'h0c, 8'h00);
        wr(6'h0f, 8'h10);
        for (int s = 0; s < 4; s++) begin
            wr(6'h0d, 8'h10 | 8'(s));
            repeat (2) @(posedge pclk);
            if (s != 0) begin
                tk(0, 3);
            end
            tk(s, 2);
            rd(6'h0e, 8'h25);
            tk(s, 1);
            rd(6'h0e, 8'h35);
            chk(32'(irq_n_oe), 32'h1);
            rel((s == 0) ? FAST : SLOW);
            tk(s, 3);
            chk(32'(irq_n_oe), 32'h1);
            wr(6'h0e, 8'h00);
            chk(32'(irq_n_oe), 32'h0);
            wr(6'h0d, 8'h00);
        end
        wr(6'h0d, 8'h10);
        repeat (2) @(posedge pclk);
        tk(0, 3);
        chk(32'(irq_n_oe), 32'h1);
        wr(6'h0f, 8'h00);
        chk(32'(irq_n_oe), 32'h0);
        wr(6'h0f, 8'h10);
        wr(6'h0e, 8'h00);
        tk(0, 3);
        chk(32'(irq_n_oe), 32'h1);
        wr(6'h0d, 8'h00);
        chk(32'(irq_n_oe), 32'h0);
        wr(6'h0e, 8'h00);
        tk(0, 3);
        rd(6'h0e, 8'h25);
        // Restart after a partial count must begin again from the preset
        wr(6'h0d, 8'h10);
        repeat (2) @(posedge pclk);
        tk(0, 2);
        wr(6'h0d, 8'h00);
        wr(6'h0d, 8'h10);
        repeat (2) @(posedge pclk);
        tk(0, 2);
        rd(6'h0e, 8'h25);
        tk(0, 1);
        rd(6'h0e, 8'h35);
        wr(6'h0e, 8'h00);
        wr(6'h0f, 8'h00);
        tk(0, 3);
        rd(6'h0e, 8'h35);
        chk(32'(irq_n_oe), 32'h0);
        wr(6'h0e, 8'h00);
        clock_halt <= 1'b1;
        wr(6'h0d, 8'h11);
        repeat (2) @(posedge pclk);
        tk(1, 3);
        rd(6'h0e, 8'h25);
        wr(6'h0d, 8'h10);
        tk(0, 3);
        rd(6'h0e, 8'h35);
        clock_halt <= 1'b0;
        wr(6'h0d, 8'h00);
        other_reqs.alarm_req <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'(irq_n_oe), 32'h1);
        other_reqs.alarm_req <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(irq_n_oe), 32'h0);
        summarize();
    end

    // Hang guard
    initial begin
        repeat (50000) @(posedge pclk);
        fails++;
        summarize();
    end
endmodule

`default_nettype wire
